// >>> ddp_pointer_unit.v
// ddp_pointer_unit.v - dual 24-bit data pointer with control register
// assumes a core that writes and reads registers by address on one clock
// and pulses ptr_move once per move addressed through the active pointer
`timescale 1ns/100ps
`default_nettype none
`include "ddp_defines.vh"

module ddp_pointer_unit #(
  parameter PW = 24 // pointer width
) (
  input wire clock, // core clock, 10 MHz
  input wire reset_n, // synchronous reset, active low
  input wire [7:0] reg_addr, // register address
  input wire reg_wr, // write strobe, one cycle
  input wire [7:0] reg_wdata, // write data
  output reg [7:0] reg_rdata, // read data, combinational from registers
  output wire reg_hit, // address decodes to this unit
  input wire ptr_load, // load whole active pointer
  input wire [PW-1:0] ptr_load_val, // value for ptr_load
  input wire ptr_move, // pointer-addressed data or code move done
  output reg [PW-1:0] active_address_pointer // selected pointer, for addressing
);

  // architectural state
  reg [7:0] ctrl_q; // control register, bits 7 and 1 held at zero
  reg [PW-1:0] main_q; // main pointer
  reg [PW-1:0] shad_q; // shadow pointer

  // next-state values from the combinational update
  reg [PW-1:0] main_d; // next main pointer
  reg [PW-1:0] shad_d; // next shadow pointer
  reg [7:0] ctrl_d; // next control register
  reg [PW-1:0] act_d; // next value of whichever pointer is active

  // decoded control fields
  wire sel; // 0 main active, 1 shadow active
  wire toggle_en; // swap selection after each pointer move
  wire [1:0] main_mode; // main post-access mode
  wire [1:0] shad_mode; // shadow post-access mode

  // decoded register write strobes, one cycle each
  wire wr_ctrl; // write to the control register
  wire wr_low; // write to low byte of the active pointer
  wire wr_high; // write to high byte of the active pointer
  wire wr_page; // write to page byte of the active pointer

  // the single active pointer path
  wire [PW-1:0] act_q; // active pointer before update
  wire [1:0] act_mode; // mode field that belongs to the active pointer
  wire [PW-1:0] act_mod; // active pointer after its post-access mode

  // apply one post-access mode to a pointer
  // increment and decrement wrap over the whole width, so a block copy
  // that runs off the top of one page carries into the next page, and only the top of the 24-bit space comes back at zero
  function [PW-1:0] post_mod;
    input [PW-1:0] p;
    input [1:0] m;
    begin
      case (m)
        `DDP_MODE_INC: post_mod = p + {{(PW-1){1'b0}}, 1'b1};
        `DDP_MODE_DEC: post_mod = p - {{(PW-1){1'b0}}, 1'b1};
        `DDP_MODE_FLIP: post_mod = {p[PW-1:1], ~p[0]};
        default: post_mod = p;
      endcase
    end
  endfunction

  // replace one byte of a pointer
  function [PW-1:0] put_byte;
    input [PW-1:0] p;
    input [1:0] idx;
    input [7:0] b;
    reg [PW-1:0] r;
    begin
      r = p;
      r[idx*8 +: 8] = b;
      put_byte = r;
    end
  endfunction

  // pick one byte of a pointer for the register view
  function [7:0] get_byte;
    input [PW-1:0] p;
    input [1:0] idx;
    begin
      get_byte = p[idx*8 +: 8];
    end
  endfunction

  // control field decode
  assign sel = ctrl_q[`DDP_BIT_SEL];
  assign toggle_en = ctrl_q[`DDP_BIT_TOGGLE];
  assign main_mode = ctrl_q[`DDP_MAIN_MODE_HI:`DDP_MAIN_MODE_LO];
  assign shad_mode = ctrl_q[`DDP_SHAD_MODE_HI:`DDP_SHAD_MODE_LO];

  // address decode, shared by reads and writes
  assign reg_hit = (reg_addr == `DDP_ADDR_CTRL) || (reg_addr == `DDP_ADDR_LOW) ||
                   (reg_addr == `DDP_ADDR_HIGH) || (reg_addr == `DDP_ADDR_PAGE);
  assign wr_ctrl = reg_wr && (reg_addr == `DDP_ADDR_CTRL);
  assign wr_low = reg_wr && (reg_addr == `DDP_ADDR_LOW);
  assign wr_high = reg_wr && (reg_addr == `DDP_ADDR_HIGH);
  assign wr_page = reg_wr && (reg_addr == `DDP_ADDR_PAGE);

  // one mux picks the active pointer; everything after it sees only that
  // one, so no path can reach the inactive pointer by mistake
  assign act_q = sel ? shad_q : main_q;
  assign act_mode = sel ? shad_mode : main_mode;
  assign act_mod = post_mod(act_q, act_mode);

  // active pointer view follows the select bit
  always @* begin
    active_address_pointer = act_q;
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `DDP_ADDR_CTRL: reg_rdata = ctrl_q;
      `DDP_ADDR_LOW: reg_rdata = get_byte(act_q, `DDP_BYTE_LOW);
      `DDP_ADDR_HIGH: reg_rdata = get_byte(act_q, `DDP_BYTE_HIGH);
      `DDP_ADDR_PAGE: reg_rdata = get_byte(act_q, `DDP_BYTE_PAGE);
      default: reg_rdata = 8'h00;
    endcase
  end

  // next state of the active pointer and the control register
  // priority is register write, then whole load, then move; a byte write
  // is taken against the stored pointer, so a move in that same cycle is
  // dropped for that pointer rather than merged
  // a control write in a move cycle also wins over the automatic swap,
  // which keeps software in charge of the selection it just wrote
  // the mode applied is the one of the pointer used by the move, and the
  // swap only changes which pointer the next move will use
  always @* begin
    main_d = main_q;
    shad_d = shad_q;
    ctrl_d = ctrl_q;
    act_d = act_q;
    if (ptr_move) begin
      act_d = act_mod;
      if (toggle_en) begin
        ctrl_d[`DDP_BIT_SEL] = ~sel;
      end
    end
    if (ptr_load) begin
      act_d = ptr_load_val;
    end
    if (wr_low) begin
      act_d = put_byte(act_q, `DDP_BYTE_LOW, reg_wdata);
    end
    if (wr_high) begin
      act_d = put_byte(act_q, `DDP_BYTE_HIGH, reg_wdata);
    end
    if (wr_page) begin
      act_d = put_byte(act_q, `DDP_BYTE_PAGE, reg_wdata);
    end
    if (wr_ctrl) begin
      ctrl_d = reg_wdata & `DDP_CTRL_WMASK;
    end
    // route the update back to the pointer that was active this cycle
    if (sel) begin
      shad_d = act_d;
    end else begin
      main_d = act_d;
    end
  end

  // state registers
  always @(posedge clock) begin
    if (!reset_n) begin
      ctrl_q <= `DDP_CTRL_RESET;
      main_q <= `DDP_PTR_RESET;
      shad_q <= `DDP_PTR_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      main_q <= main_d;
      shad_q <= shad_d;
    end
  end

endmodule // ddp_pointer_unit

`default_nettype wire

// >>> ddp_defines.vh
// ddp_defines.vh - constants for the dual data pointer unit
// assumes inclusion by bare name from the design file; definitions only
`ifndef DDP_DEFINES_VH
`define DDP_DEFINES_VH

// special function register addresses
`define DDP_ADDR_CTRL 8'hA7
`define DDP_ADDR_LOW 8'h82
`define DDP_ADDR_HIGH 8'h83
`define DDP_ADDR_PAGE 8'h84

// control register fields and reset value
`define DDP_CTRL_RESET 8'h00
`define DDP_CTRL_WMASK 8'h7D
`define DDP_BIT_SEL 0
`define DDP_BIT_TOGGLE 6
`define DDP_MAIN_MODE_LO 2
`define DDP_MAIN_MODE_HI 3
`define DDP_SHAD_MODE_LO 4
`define DDP_SHAD_MODE_HI 5

// post-access modification modes
`define DDP_MODE_KEEP 2'h0
`define DDP_MODE_INC 2'h1
`define DDP_MODE_DEC 2'h2
`define DDP_MODE_FLIP 2'h3

// pointer reset value
`define DDP_PTR_RESET 24'h000000

// byte positions of the pointer in the register view
`define DDP_BYTE_LOW 2'h0
`define DDP_BYTE_HIGH 2'h1
`define DDP_BYTE_PAGE 2'h2

`endif

// >>> ddp_checker_sva.sv
// port checks for ddp_pointer_unit
// assumes bind into the unit; ctrl seen only while addressed
`timescale 1ns/100ps
`default_nettype none
`include "ddp_defines.vh"
module ddp_checker #(parameter PW = 24) (
  input wire clock, // clk
  input wire reset_n, // reset
  input wire [7:0] reg_addr, // addr
  input wire reg_wr, // wr
  input wire [7:0] reg_wdata, // wdata
  input wire [7:0] reg_rdata, // rdata
  input wire reg_hit, // hit
  input wire ptr_load, // load
  input wire [PW-1:0] ptr_load_val, // load value
  input wire ptr_move, // move
  input wire [PW-1:0] active_address_pointer // pointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ctrl only readable while addressed, so checks key on ctl
  wire ctl = reg_addr == `DDP_ADDR_CTRL;
  wire [1:0] mode = reg_rdata[0] ? reg_rdata[5:4] : reg_rdata[3:2];
  function [PW-1:0] f_mod(input [PW-1:0] p, input [1:0] m);
    f_mod = m == 2'h1 ? p + 1'b1 : m == 2'h2 ? p - 1'b1 : m == 2'h3 ? p ^ 1'b1 : p;
  endfunction
  sequence s_move;
    ctl && ptr_move && !reg_wr && !ptr_load;
  endsequence
  a_ctrl_reserved:
    assert property (ctl |-> !reg_rdata[7] && !reg_rdata[1]) else $error("reserved bit");
  a_ctrl_write:
    assert property (ctl && reg_wr |=> !ctl || reg_rdata == ($past(reg_wdata) & 8'h7D))
    else $error("ctrl write");
  a_hit_decode:
    assert property (reg_hit == (ctl || (reg_addr >= 8'h82 && reg_addr <= 8'h84)))
    else $error("decode");
  a_bytes_show:
    assert property (reg_hit && !ctl |->
      reg_rdata == active_address_pointer[(reg_addr - 8'h82) * 8 +: 8]) else $error("byte");
  a_load_active:
    assert property (ptr_load && !reg_wr && !ptr_move |=>
      active_address_pointer == $past(ptr_load_val))
    else $error("load");
  a_idle_hold:
    assert property (!reg_wr && !ptr_load && !ptr_move |=> $stable(active_address_pointer))
    else $error("pointer moved");
  a_move_mode:
    assert property (s_move ##0 !reg_rdata[6] |=>
      active_address_pointer == f_mod($past(active_address_pointer), $past(mode)))
    else $error("mode");
  a_toggle_swap:
    assert property (s_move |=> !ctl || reg_rdata[0] == ($past(reg_rdata[0]) ^ $past(reg_rdata[6])))
    else $error("toggle");
endmodule // ddp_checker
bind ddp_pointer_unit ddp_checker #(.PW(PW)) ddp_checker_inst (.*);
`default_nettype wire

// >>> ddp_core_model.sv
// core model: one move strobe per pointer-addressed move
// assumes the shared clock; drives on the falling edge
`timescale 1ns/100ps
`default_nettype none
module ddp_core_model (
  input wire clock, // clk
  output logic ptr_move // move strobe
);
  // pc and @ri moves never strobe, so pointers stay put
  initial ptr_move = 1'b0;
  task move;
    ptr_move = 1'b1;
    @(negedge clock);
    ptr_move = 1'b0;
  endtask
endmodule // ddp_core_model
`default_nettype wire

// >>> test_dual_data_pointer_unit.sv
// bench for ddp_pointer_unit with the core model
// assumes 10 MHz clock; inputs change on falling edge
`timescale 1ns/100ps
`default_nettype none
`include "ddp_defines.vh"
module test_dual_data_pointer_unit;
  logic clock = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, ptr_load = 1'b0, reg_hit, ptr_move;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [23:0] ptr_load_val = 24'h000000, active_address_pointer;
  int err_count = 0, n_checks = 0;
  // ctrl written, value loaded, pointer expected, ctrl expected
  logic [63:0] rows [10] = '{64'h00_123456_123456_00, 64'h04_00FFFF_010000_04,
    64'h08_000000_FFFFFF_08, 64'h0C_ABCDEF_ABCDEE_0C, 64'h11_FFFFFF_000000_11,
    64'h21_010000_00FFFF_21, 64'h31_000010_000011_31, 64'h01_777777_777777_01,
    64'h55_00D000_ABCDEE_54, 64'hFF_000000_ABCDEE_7C};
  ddp_pointer_unit ddp_pointer_unit_inst (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .ptr_move(ptr_move),
    .active_address_pointer(active_address_pointer));
  ddp_core_model ddp_core_model_inst (.clock(clock), .ptr_move(ptr_move));
  initial forever #50 clock = ~clock;
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // called on a falling edge, returns one cycle later, on the next falling edge
  task wr(input [7:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      wr(`DDP_ADDR_CTRL, rows[i][63:56]);
      ptr_load = 1'b1;
      ptr_load_val = rows[i][55:32];
      @(negedge clock);
      ptr_load = 1'b0;
      ddp_core_model_inst.move();
      #1 chk(active_address_pointer, rows[i][31:8]);
      chk(reg_rdata, rows[i][7:0]);
      for (int k = 0; k < 3; k++) begin
        @(negedge clock);
        reg_addr = 8'(8'h82 + k);
        #1 chk(reg_rdata, rows[i][8 + 8 * k +: 8]);
      end
    end
    // increment of a read-back 7D lands on select only
    @(negedge clock);
    wr(`DDP_ADDR_CTRL, 8'h7D);
    @(negedge clock);
    wr(`DDP_ADDR_CTRL, 8'h7E);
    #1 chk(reg_rdata, 8'h7C);
    @(negedge clock);
    reg_addr = 8'h00;
    #1 chk({reg_hit, reg_rdata}, 9'h000);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    reg_addr = `DDP_ADDR_CTRL;
    #1 chk({reg_rdata, active_address_pointer}, 32'h00000000);
    summarize();
  end
endmodule // test_dual_data_pointer_unit
`default_nettype wire
